/* File: sleep_ctrl_pkg.sv */
// Package for the sleep mode controller: mode encodings, clock gate indices, widths.
// Assumes one reference clock domain; consumers reference everything as sleep_ctrl_pkg::name.
package sleep_ctrl_pkg;

  localparam int MODE_W = 3;

  // Software mode codes; other codes are refused
  localparam logic [MODE_W-1:0] MODE_IDLE      = 3'h0;
  localparam logic [MODE_W-1:0] MODE_ADC_NR    = 3'h1;
  localparam logic [MODE_W-1:0] MODE_PWR_DOWN  = 3'h2;
  localparam logic [MODE_W-1:0] MODE_PWR_SAVE  = 3'h3;
  localparam logic [MODE_W-1:0] MODE_STANDBY   = 3'h6;

  // Clock enable vector bit positions
  localparam int GATE_W       = 6;
  localparam int GATE_CPU     = 0;
  localparam int GATE_IO      = 1;
  localparam int GATE_ADC     = 2;
  localparam int GATE_ASYNC   = 3;
  localparam int GATE_OSC     = 4;
  localparam int GATE_IRQ     = 5;

  localparam logic [GATE_W-1:0] GATES_ALL_ON  = 6'h3F;
  localparam logic [GATE_W-1:0] GATES_ALL_OFF = 6'h00;

  // Cycles between each restore step during wake-up
  localparam int WAKE_STEP_CYCLES = 2;
  localparam int WAKE_CNT_W       = 4;

  // Cycles of clocked reset after release of the asynchronous reset
  localparam int RESET_HOLD_CYCLES = 4;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_SLEEP,
    ST_WAKE_OSC,
    ST_WAKE_PERI,
    ST_WAKE_CPU
  } sleep_state_e;

endpackage : sleep_ctrl_pkg

/* File: sleep_mode_controller.sv */
// Sleep mode controller: gates clocks per selected power saving mode, wakes on
// interrupt or reset, and tristates the general-purpose ports on reset.
// Assumes inputs synchronous to i_ref_clk; clock gating cells downstream latch the enables.
`timescale 1ns/100ps
module sleep_mode_controller #(
  parameter int PORT_W = 53
) (
  input  wire logic                              i_ref_clk,
  input  wire logic                              i_arst_n,
  input  wire logic [sleep_ctrl_pkg::MODE_W-1:0] i_mode,
  input  wire logic                              i_sleep_en,
  input  wire logic                              i_sleep_req,
  input  wire logic                              i_wake_irq,
  input  wire logic [PORT_W-1:0]                 i_port_oe,
  output logic      [PORT_W-1:0]                 o_port_oe,
  output logic                                   o_cpu_clk_en,
  output logic                                   o_io_clk_en,
  output logic                                   o_adc_clk_en,
  output logic                                   o_async_clk_en,
  output logic                                   o_osc_en,
  output logic                                   o_irq_clk_en,
  output logic                                   o_sleeping,
  output logic                                   o_core_rst_n,
  output logic                                   o_mode_err
);

  // Refused at elaboration: a zero-width port vector has nothing to tristate
  if (PORT_W < 1)
  begin : g_port_w_check
    $error("PORT_W must be at least 1");
  end

  // Clock enables kept in each mode
  function automatic logic [sleep_ctrl_pkg::GATE_W-1:0] mode_gates(
    input logic [sleep_ctrl_pkg::MODE_W-1:0] mode
  );
    logic [sleep_ctrl_pkg::GATE_W-1:0] g;
    g = sleep_ctrl_pkg::GATES_ALL_OFF;
    case (mode)
      sleep_ctrl_pkg::MODE_IDLE:
      begin
        g = sleep_ctrl_pkg::GATES_ALL_ON;
        g[sleep_ctrl_pkg::GATE_CPU] = 1'b0;
      end
      sleep_ctrl_pkg::MODE_ADC_NR:
      begin
        g[sleep_ctrl_pkg::GATE_OSC]   = 1'b1;
        g[sleep_ctrl_pkg::GATE_ADC]   = 1'b1;
        g[sleep_ctrl_pkg::GATE_ASYNC] = 1'b1;
        g[sleep_ctrl_pkg::GATE_IRQ]   = 1'b1;
      end
      sleep_ctrl_pkg::MODE_PWR_SAVE:
      begin
        g[sleep_ctrl_pkg::GATE_ASYNC] = 1'b1;
      end
      sleep_ctrl_pkg::MODE_STANDBY:
      begin
        g[sleep_ctrl_pkg::GATE_OSC] = 1'b1;
      end
      default:
      begin
        g = sleep_ctrl_pkg::GATES_ALL_OFF;
      end
    endcase
    return g;
  endfunction : mode_gates

  function automatic logic mode_valid(
    input logic [sleep_ctrl_pkg::MODE_W-1:0] mode
  );
    return (mode == sleep_ctrl_pkg::MODE_IDLE)     ||
           (mode == sleep_ctrl_pkg::MODE_ADC_NR)   ||
           (mode == sleep_ctrl_pkg::MODE_PWR_DOWN) ||
           (mode == sleep_ctrl_pkg::MODE_PWR_SAVE) ||
           (mode == sleep_ctrl_pkg::MODE_STANDBY);
  endfunction : mode_valid

  // Reset stretcher: core logic leaves reset only on clock edges
  logic [3:0] rst_cnt;
  logic [3:0] next_rst_cnt;
  logic       core_rst_n;
  logic       next_core_rst_n;

  always_comb
  begin
    next_rst_cnt    = rst_cnt;
    next_core_rst_n = core_rst_n;
    if (rst_cnt != 4'(sleep_ctrl_pkg::RESET_HOLD_CYCLES))
    begin
      next_rst_cnt = rst_cnt + 4'h1;
    end
    else
    begin
      next_core_rst_n = 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      rst_cnt    <= 4'h0;
      core_rst_n <= 1'b0;
    end
    else
    begin
      rst_cnt    <= next_rst_cnt;
      core_rst_n <= next_core_rst_n;
    end
  end

  // Sleep sequencer
  sleep_ctrl_pkg::sleep_state_e state;
  sleep_ctrl_pkg::sleep_state_e next_state;
  logic [sleep_ctrl_pkg::GATE_W-1:0]     gates;
  logic [sleep_ctrl_pkg::GATE_W-1:0]     next_gates;
  logic [sleep_ctrl_pkg::WAKE_CNT_W-1:0] wcnt;
  logic [sleep_ctrl_pkg::WAKE_CNT_W-1:0] next_wcnt;
  logic                                  mode_err;
  logic                                  next_mode_err;
  logic                                  step_done;
  logic                                  sleeping;
  logic                                  next_sleeping;

  assign step_done = (wcnt == sleep_ctrl_pkg::WAKE_CNT_W'(sleep_ctrl_pkg::WAKE_STEP_CYCLES - 1));

  always_comb
  begin
    next_state    = state;
    next_gates    = gates;
    next_wcnt     = '0;
    next_mode_err = mode_err;
    if (!core_rst_n)
    begin
      next_state    = sleep_ctrl_pkg::ST_RUN;
      next_gates    = sleep_ctrl_pkg::GATES_ALL_ON;
      next_mode_err = 1'b0;
    end
    else
    begin
      case (state)
        sleep_ctrl_pkg::ST_RUN:
        begin
          if (i_sleep_req && i_sleep_en && !i_wake_irq)
          begin
            if (mode_valid(i_mode))
            begin
              next_state    = sleep_ctrl_pkg::ST_SLEEP;
              next_gates    = mode_gates(i_mode);
              next_mode_err = 1'b0;
            end
            else
            begin
              next_mode_err = 1'b1;
            end
          end
        end
        sleep_ctrl_pkg::ST_SLEEP:
        begin
          // Oscillator first, then peripherals, CPU last
          if (i_wake_irq)
          begin
            next_state = sleep_ctrl_pkg::ST_WAKE_OSC;
            next_gates[sleep_ctrl_pkg::GATE_OSC] = 1'b1;
          end
        end
        sleep_ctrl_pkg::ST_WAKE_OSC:
        begin
          next_wcnt = wcnt + 1'b1;
          if (step_done)
          begin
            next_wcnt  = '0;
            next_state = sleep_ctrl_pkg::ST_WAKE_PERI;
            next_gates = sleep_ctrl_pkg::GATES_ALL_ON;
            next_gates[sleep_ctrl_pkg::GATE_CPU] = 1'b0;
          end
        end
        sleep_ctrl_pkg::ST_WAKE_PERI:
        begin
          next_wcnt = wcnt + 1'b1;
          if (step_done)
          begin
            next_wcnt  = '0;
            next_state = sleep_ctrl_pkg::ST_WAKE_CPU;
            next_gates = sleep_ctrl_pkg::GATES_ALL_ON;
          end
        end
        sleep_ctrl_pkg::ST_WAKE_CPU:
        begin
          next_state = sleep_ctrl_pkg::ST_RUN;
        end
        default:
        begin
          next_state = sleep_ctrl_pkg::ST_RUN;
          next_gates = sleep_ctrl_pkg::GATES_ALL_ON;
        end
      endcase
    end
    // Registered status so the output needs no decode after the flop
    next_sleeping = (next_state != sleep_ctrl_pkg::ST_RUN);
  end

  // Enables change only on clock edges or at asynchronous reset, so gating cells never see a glitch
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      state    <= sleep_ctrl_pkg::ST_RUN;
      gates    <= sleep_ctrl_pkg::GATES_ALL_ON;
      wcnt     <= '0;
      mode_err <= 1'b0;
      sleeping <= 1'b0;
    end
    else
    begin
      state    <= next_state;
      gates    <= next_gates;
      wcnt     <= next_wcnt;
      mode_err <= next_mode_err;
      sleeping <= next_sleeping;
    end
  end

  // Port enables: cleared asynchronously, works with the clock stopped
  logic [PORT_W-1:0] port_oe;
  logic [PORT_W-1:0] next_port_oe;

  always_comb
  begin
    next_port_oe = core_rst_n ? i_port_oe : '0;
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      port_oe <= '0;
    end
    else
    begin
      port_oe <= next_port_oe;
    end
  end

  assign o_port_oe      = port_oe;
  assign o_cpu_clk_en   = gates[sleep_ctrl_pkg::GATE_CPU];
  assign o_io_clk_en    = gates[sleep_ctrl_pkg::GATE_IO];
  assign o_adc_clk_en   = gates[sleep_ctrl_pkg::GATE_ADC];
  assign o_async_clk_en = gates[sleep_ctrl_pkg::GATE_ASYNC];
  assign o_osc_en       = gates[sleep_ctrl_pkg::GATE_OSC];
  assign o_irq_clk_en   = gates[sleep_ctrl_pkg::GATE_IRQ];
  assign o_sleeping     = sleeping;
  assign o_core_rst_n   = core_rst_n;
  assign o_mode_err     = mode_err;

endmodule : sleep_mode_controller

/* File: sleep_mode_controller_asserts.sv */
// Checker for the sleep mode controller, bound onto its top module.
// Assumes sleep_ctrl_pkg is compiled first.
`timescale 1ns/100ps
module sleep_mode_controller_asserts #(
  parameter int PORT_W = 53
) (
  input wire logic              i_ref_clk,
  input wire logic              i_arst_n,
  input wire logic [2:0]        i_mode,
  input wire logic              i_sleep_en,
  input wire logic              i_sleep_req,
  input wire logic              i_wake_irq,
  input wire logic [PORT_W-1:0] i_port_oe,
  input wire logic [PORT_W-1:0] o_port_oe,
  input wire logic              o_cpu_clk_en,
  input wire logic              o_io_clk_en,
  input wire logic              o_adc_clk_en,
  input wire logic              o_async_clk_en,
  input wire logic              o_osc_en,
  input wire logic              o_irq_clk_en,
  input wire logic              o_sleeping,
  input wire logic              o_core_rst_n,
  input wire logic              o_mode_err
);
  wire logic [5:0] en = {o_irq_clk_en, o_osc_en, o_async_clk_en, o_adc_clk_en,
                         o_io_clk_en, o_cpu_clk_en};
  wire logic       ok = i_mode inside {3'h0, 3'h1, 3'h2, 3'h3, 3'h6};
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);
  a_port_tri: assert property (!o_core_rst_n |-> o_port_oe == '0)
    else $error("ports driven in core reset");
  a_port_follow: assert property (o_core_rst_n && $past(o_core_rst_n) |->
    o_port_oe == $past(i_port_oe)) else $error("port enables not followed");
  a_core_hold: assert property ($rose(o_core_rst_n) |-> !$past(o_core_rst_n, 4))
    else $error("core reset released early");
  a_idle_set: assert property ($rose(o_sleeping) &&
    $past(i_mode) == sleep_ctrl_pkg::MODE_IDLE |-> en == 6'h3e) else $error("idle set");
  a_pdown_set: assert property ($rose(o_sleeping) &&
    $past(i_mode) == sleep_ctrl_pkg::MODE_PWR_DOWN |-> en == 6'h00) else $error("pdown set");
  a_psave_set: assert property ($rose(o_sleeping) &&
    $past(i_mode) == sleep_ctrl_pkg::MODE_PWR_SAVE |-> en == 6'h08) else $error("psave set");
  a_adc_set: assert property ($rose(o_sleeping) &&
    $past(i_mode) == sleep_ctrl_pkg::MODE_ADC_NR |-> en == 6'h3c) else $error("adc set");
  a_stby_set: assert property ($rose(o_sleeping) &&
    $past(i_mode) == sleep_ctrl_pkg::MODE_STANDBY |-> en == 6'h10) else $error("stby set");
  a_bad_mode: assert property ($past(i_sleep_req && i_sleep_en && !i_wake_irq &&
    !o_sleeping && o_core_rst_n && !ok) |-> o_mode_err && !o_sleeping)
    else $error("invalid mode accepted");
  a_cpu_last: assert property ($rose(o_cpu_clk_en) |-> $past(en[5:1]) == 5'h1f)
    else $error("processor clock before others");
endmodule : sleep_mode_controller_asserts

bind sleep_mode_controller sleep_mode_controller_asserts #(
  .PORT_W(PORT_W)
) i_chk (
  .i_ref_clk      (i_ref_clk),
  .i_arst_n       (i_arst_n),
  .i_mode         (i_mode),
  .i_sleep_en     (i_sleep_en),
  .i_sleep_req    (i_sleep_req),
  .i_wake_irq     (i_wake_irq),
  .i_port_oe      (i_port_oe),
  .o_port_oe      (o_port_oe),
  .o_cpu_clk_en   (o_cpu_clk_en),
  .o_io_clk_en    (o_io_clk_en),
  .o_adc_clk_en   (o_adc_clk_en),
  .o_async_clk_en (o_async_clk_en),
  .o_osc_en       (o_osc_en),
  .o_irq_clk_en   (o_irq_clk_en),
  .o_sleeping     (o_sleeping),
  .o_core_rst_n   (o_core_rst_n),
  .o_mode_err     (o_mode_err)
);

/* File: sleep_mode_controller_tb.sv */
// Self-checking bench: mode entry, wake sequence, refusals and resets.
// Assumes the design and its checker are compiled first.
`timescale 1ns/100ps
module sleep_mode_controller_tb;
  localparam int PW = 53;
  // Reset starts high so its first fall clears the design before any clock edge
  logic          i_ref_clk = 0, i_arst_n = 1, i_sleep_en = 1;
  logic          i_sleep_req = 0, i_wake_irq = 0;
  logic [2:0]    i_mode = 0;
  logic [PW-1:0] i_port_oe = 0, o_port_oe, pv = 0;
  logic          o_cpu_clk_en, o_io_clk_en, o_adc_clk_en, o_async_clk_en;
  logic          o_osc_en, o_irq_clk_en, o_sleeping, o_core_rst_n, o_mode_err;
  logic [61:0]   notes[$];
  int            error_cnt = 0, num_checks = 0, seed = 32'h2d54;
  wire  [61:0]   seen = {o_port_oe, o_sleeping, o_mode_err, o_core_rst_n, o_irq_clk_en,
                         o_osc_en, o_async_clk_en, o_adc_clk_en, o_io_clk_en, o_cpu_clk_en};

  always #50 i_ref_clk = ~i_ref_clk;
  sleep_mode_controller #(
    .PORT_W(PW)
  ) i_sleep_mode_controller (
    .i_ref_clk      (i_ref_clk),
    .i_arst_n       (i_arst_n),
    .i_mode         (i_mode),
    .i_sleep_en     (i_sleep_en),
    .i_sleep_req    (i_sleep_req),
    .i_wake_irq     (i_wake_irq),
    .i_port_oe      (i_port_oe),
    .o_port_oe      (o_port_oe),
    .o_cpu_clk_en   (o_cpu_clk_en),
    .o_io_clk_en    (o_io_clk_en),
    .o_adc_clk_en   (o_adc_clk_en),
    .o_async_clk_en (o_async_clk_en),
    .o_osc_en       (o_osc_en),
    .o_irq_clk_en   (o_irq_clk_en),
    .o_sleeping     (o_sleeping),
    .o_core_rst_n   (o_core_rst_n),
    .o_mode_err     (o_mode_err)
  );

  task automatic check(string nm, logic [61:0] exp, logic [61:0] got);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected %s exp %h got %h", nm, exp, got);
    end
  endtask : check

  // Note one expected edge, then move the port enables at the falling edge
  task automatic tick(logic sl, logic er, logic rn, logic pz, logic [5:0] en);
    @(posedge i_ref_clk);
    notes.push_back({(pz ? {PW{1'b0}} : pv), sl, er, rn, en});
    @(negedge i_ref_clk);
    pv = PW'({$random(seed), $random(seed)});
    i_port_oe = pv;
  endtask : tick

  always @(negedge i_ref_clk)
    while (notes.size() > 0)
      check("outputs", notes.pop_front(), seen);

  // Delayed off the edge so the monitor has read the last note first
  task automatic do_reset();
    #20 i_arst_n = 0;
    #10 check("reset", {{PW{1'b0}}, 3'b000, 6'h3f}, seen);
    repeat (3) @(negedge i_ref_clk);
    i_arst_n = 1;
    repeat (4) tick(0, 0, 0, 1, 6'h3f);
    tick(0, 0, 1, 1, 6'h3f);
  endtask : do_reset

  task automatic nap(logic [2:0] m, logic [5:0] set);
    i_mode = m;
    i_sleep_req = 1;
    tick(1, 0, 1, 0, set);
    i_sleep_req = 0;
    repeat (2) tick(1, 0, 1, 0, set);
    i_wake_irq = 1;
    repeat (2) tick(1, 0, 1, 0, set | 6'h10);
    i_wake_irq = 0;
    repeat (2) tick(1, 0, 1, 0, 6'h3e);
    tick(1, 0, 1, 0, 6'h3f);
    tick(0, 0, 1, 0, 6'h3f);
  endtask : nap

  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_of_test

  initial
  begin
    #200000;
    error_cnt++;
    end_of_test();
  end

  initial
  begin
    do_reset();
    tick(0, 0, 1, 0, 6'h3f);
    nap(sleep_ctrl_pkg::MODE_IDLE, 6'h3e);
    nap(sleep_ctrl_pkg::MODE_ADC_NR, 6'h3c);
    nap(sleep_ctrl_pkg::MODE_PWR_SAVE, 6'h08);
    nap(sleep_ctrl_pkg::MODE_STANDBY, 6'h10);
    nap(sleep_ctrl_pkg::MODE_PWR_DOWN, 6'h00);
    for (int k = 4; k < 8; k++)
      if (k != 6)
      begin
        i_mode = k[2:0];
        i_sleep_req = 1;
        tick(0, 1, 1, 0, 6'h3f);
        i_sleep_req = 0;
        tick(0, 1, 1, 0, 6'h3f);
      end
    // Pending interrupt, then low enable, must both block entry
    i_mode = sleep_ctrl_pkg::MODE_IDLE;
    i_sleep_req = 1;
    i_wake_irq = 1;
    tick(0, 1, 1, 0, 6'h3f);
    i_wake_irq = 0;
    i_sleep_en = 0;
    tick(0, 1, 1, 0, 6'h3f);
    i_sleep_en = 1;
    i_sleep_req = 0;
    nap(sleep_ctrl_pkg::MODE_IDLE, 6'h3e);
    i_mode = sleep_ctrl_pkg::MODE_PWR_DOWN;
    i_sleep_req = 1;
    tick(1, 0, 1, 0, 6'h00);
    i_sleep_req = 0;
    do_reset();
    tick(0, 0, 1, 0, 6'h3f);
    // Let the monitor take the last note before the verdict
    @(posedge i_ref_clk);
    end_of_test();
  end
endmodule : sleep_mode_controller_tb
